// ### rtl/rcak_rtc.sv
// calendar counter, alarm comparator, power keys and reset debounce
// assumes one AHB-Lite master; osc_32k and sysrst_in_n are synchronous
`timescale 1ns/1ps
`default_nettype none
module rcak_rtc
  import rcak_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        osc_32k,
  input  wire logic        sysrst_in_n,
  output logic             sysrst_deb_n,
  output logic             alarm_irq,
  output logic             core_power_o
);

  // ****************
  // helpers
  // ****************
  function automatic logic [4:0] month_len(input logic [3:0] m,
                                           input logic [6:0] y);
    case (m)
      4'h2:    month_len = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4,
      4'h6,
      4'h9,
      4'hB:    month_len = 5'h1E;
      default: month_len = 5'h1F;
    endcase
  endfunction

  function automatic logic [11:0] deb_ms(input logic [2:0] c);
    case (c)
      3'h0:    deb_ms = 12'h002;
      3'h1:    deb_ms = 12'h008;
      3'h2:    deb_ms = 12'h020;
      3'h3:    deb_ms = 12'h080;
      3'h4:    deb_ms = 12'h100;
      3'h5:    deb_ms = 12'h200;
      3'h6:    deb_ms = 12'h400;
      default: deb_ms = 12'h800;
    endcase
  endfunction

  // ****************
  // state
  // ****************
  logic [5:0]  sec_reg, min_reg, asec_reg, amin_reg;
  logic [4:0]  hou_reg, dom_reg, ahou_reg, adom_reg;
  logic [2:0]  dow_reg, adow_reg;
  logic [3:0]  mth_reg, amth_reg;
  logic [6:0]  yea_reg, ayea_reg;
  logic [6:0]  mask_reg;
  logic [15:0] keya_reg, keyb_reg, spar_reg;
  logic [7:0]  debsp_reg, spare2_reg;
  logic [1:0]  ctrl_reg;
  logic        wr_ph_reg;
  logic [7:0]  wr_addr_reg;
  logic        pend_reg;
  logic [7:0]  pend_addr_reg;
  logic [15:0] pend_data_reg;
  logic [2:0]  pend_cnt_reg;
  logic        osc_reg;
  logic [14:0] osc_cnt_reg;
  logic        tick_reg;
  logic        tick_d_reg;
  logic [15:0] ms_cnt_reg;
  logic [11:0] ms_num_reg;
  logic        deb_busy;
  logic        new_wr;
  logic        commit;
  logic        keys_ok;
  logic        alarm_hit;

  assign keys_ok = (keya_reg == KEY_A_OK) && (keyb_reg == KEY_B_OK);
  assign new_wr  = wr_ph_reg;
  // commit early when a second write arrives, keeping one slot honest
  assign commit  = pend_reg && (pend_cnt_reg == 3'h0 || new_wr);
  assign deb_busy = (sysrst_in_n != sysrst_deb_n);

  // ****************
  // bus slave
  // ****************
  function automatic logic [15:0] rd_word(input logic [7:0] a);
    logic [14:0] v;
    v = 15'h0000;
    if (a == OFS_CTRL)        v = {13'h0000, ctrl_reg};
    else if (a == OFS_MASK)   v = {8'h00, mask_reg};
    else if (a == OFS_TSEC)   v = {9'h000, sec_reg};
    else if (a == OFS_TMIN)   v = {9'h000, min_reg};
    else if (a == OFS_THOU)   v = {10'h000, hou_reg};
    else if (a == OFS_TDOM)   v = {10'h000, dom_reg};
    else if (a == OFS_TDOW)   v = {12'h000, dow_reg};
    else if (a == OFS_TMTH)   v = {11'h000, mth_reg};
    else if (a == OFS_TYEA)   v = {8'h00, yea_reg};
    else if (a == OFS_ASEC)   v = {9'h000, asec_reg};
    else if (a == OFS_AMIN)   v = {9'h000, amin_reg};
    else if (a == OFS_AHOU)   v = {10'h000, ahou_reg};
    else if (a == OFS_ADOM)   v = {10'h000, adom_reg};
    else if (a == OFS_ADOW)   v = {12'h000, adow_reg};
    else if (a == OFS_AMTH)   v = {11'h000, amth_reg};
    else if (a == OFS_AYEA)   v = {8'h00, ayea_reg};
    else if (a == OFS_KEYA)   v = keya_reg[14:0];
    else if (a == OFS_KEYB)   v = keyb_reg[14:0];
    else if (a == OFS_DEBSP)  v = {deb_busy, 6'h00, debsp_reg};
    else if (a == OFS_SPARE2) v = {7'h00, spare2_reg};
    else if (a == OFS_WOK)
      v = {12'h000,
           pend_reg && pend_addr_reg == OFS_CTRL,
           pend_reg && pend_addr_reg == OFS_KEYB,
           pend_reg && pend_addr_reg == OFS_KEYA};
    else if (a == OFS_SPAR)   v = spar_reg[14:0];
    if (a == OFS_KEYA || a == OFS_KEYB || a == OFS_SPAR)
      rd_word = {(a == OFS_KEYA) ? keya_reg[15] :
                 (a == OFS_KEYB) ? keyb_reg[15] : spar_reg[15], v};
    else if (a == OFS_WOK || a == OFS_CTRL)
      rd_word = {1'b0, v};
    else
      rd_word = {pend_reg && pend_addr_reg == a, v};
  endfunction

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
      wr_ph_reg   <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      // zero wait states, always OKAY
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_ph_reg <= 1'b0;
      if (hsel && htrans[1] && hready)
      begin
        wr_ph_reg   <= hwrite;
        wr_addr_reg <= haddr[7:0];
        if (!hwrite)
          hrdata <= {16'h0000, rd_word(haddr[7:0])};
      end
    end
  end

  // ****************
  // write commit slot
  // ****************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_reg      <= 1'b0;
      pend_addr_reg <= 8'h00;
      pend_data_reg <= 16'h0000;
      pend_cnt_reg  <= 3'h0;
    end
    else if (new_wr)
    begin
      pend_reg      <= 1'b1;
      pend_addr_reg <= wr_addr_reg;
      pend_data_reg <= hwdata[15:0];
      pend_cnt_reg  <= COMMIT_CYC;
    end
    else if (commit)
      pend_reg <= 1'b0;
    else if (pend_reg)
      pend_cnt_reg <= pend_cnt_reg - 3'h1;
  end

  // ****************
  // timebase
  // ****************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_reg     <= 1'b0;
      osc_cnt_reg <= 15'h0000;
      tick_reg    <= 1'b0;
      tick_d_reg  <= 1'b0;
    end
    else
    begin
      osc_reg    <= osc_32k;
      tick_d_reg <= tick_reg;
      tick_reg   <= 1'b0;
      if (osc_32k && !osc_reg)
      begin
        osc_cnt_reg <= osc_cnt_reg + 15'h0001;
        tick_reg    <= (osc_cnt_reg == OSC_PER_SEC);
      end
    end
  end

  // ****************
  // calendar and registers
  // ****************
  // zero keys read as unprogrammed; time is not meaningful until set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {sec_reg, min_reg, hou_reg} <= 17'h00000;
      dom_reg  <= DOM_RST;
      dow_reg  <= DOW_RST;
      mth_reg  <= MTH_RST;
      yea_reg  <= 7'h00;
      {asec_reg, amin_reg, ahou_reg} <= 17'h00000;
      adom_reg <= DOM_RST;
      adow_reg <= DOW_RST;
      amth_reg <= MTH_RST;
      ayea_reg <= 7'h00;
      mask_reg <= 7'h00;
      keya_reg <= 16'h0000;
      keyb_reg <= 16'h0000;
      spar_reg <= 16'h0000;
      debsp_reg  <= 8'h00;
      spare2_reg <= 8'h00;
      ctrl_reg   <= 2'h0;
    end
    else
    begin
      if (tick_reg)
      begin
        sec_reg <= (sec_reg >= SEC_MAX) ? 6'h00 : sec_reg + 6'h01;
        if (sec_reg >= SEC_MAX)
        begin
          min_reg <= (min_reg >= MIN_MAX) ? 6'h00 : min_reg + 6'h01;
          if (min_reg >= MIN_MAX)
          begin
            hou_reg <= (hou_reg >= HOU_MAX) ? 5'h00 : hou_reg + 5'h01;
            if (hou_reg >= HOU_MAX)
            begin
              dow_reg <= (dow_reg >= DOW_MAX) ? DOW_RST
                                              : dow_reg + 3'h1;
              if (dom_reg >= month_len(mth_reg, yea_reg))
              begin
                dom_reg <= DOM_RST;
                mth_reg <= (mth_reg >= MTH_MAX) ? MTH_RST
                                                : mth_reg + 4'h1;
                if (mth_reg >= MTH_MAX)
                  yea_reg <= yea_reg + 7'h01;
              end
              else
                dom_reg <= dom_reg + 5'h01;
            end
          end
        end
      end
      // software sets fields, ranges kept by writer
      if (commit)
      begin
        if (pend_addr_reg == OFS_TSEC)      sec_reg <= pend_data_reg[5:0];
        else if (pend_addr_reg == OFS_TMIN) min_reg <= pend_data_reg[5:0];
        else if (pend_addr_reg == OFS_THOU) hou_reg <= pend_data_reg[4:0];
        else if (pend_addr_reg == OFS_TDOM) dom_reg <= pend_data_reg[4:0];
        else if (pend_addr_reg == OFS_TDOW) dow_reg <= pend_data_reg[2:0];
        else if (pend_addr_reg == OFS_TMTH) mth_reg <= pend_data_reg[3:0];
        else if (pend_addr_reg == OFS_TYEA) yea_reg <= pend_data_reg[6:0];
        else if (pend_addr_reg == OFS_ASEC) asec_reg <= pend_data_reg[5:0];
        else if (pend_addr_reg == OFS_AMIN) amin_reg <= pend_data_reg[5:0];
        else if (pend_addr_reg == OFS_AHOU) ahou_reg <= pend_data_reg[4:0];
        else if (pend_addr_reg == OFS_ADOM) adom_reg <= pend_data_reg[4:0];
        else if (pend_addr_reg == OFS_ADOW) adow_reg <= pend_data_reg[2:0];
        else if (pend_addr_reg == OFS_AMTH) amth_reg <= pend_data_reg[3:0];
        else if (pend_addr_reg == OFS_AYEA) ayea_reg <= pend_data_reg[6:0];
        else if (pend_addr_reg == OFS_MASK) mask_reg <= pend_data_reg[6:0];
        else if (pend_addr_reg == OFS_KEYA) keya_reg <= pend_data_reg;
        else if (pend_addr_reg == OFS_KEYB) keyb_reg <= pend_data_reg;
        else if (pend_addr_reg == OFS_DEBSP) debsp_reg <= pend_data_reg[7:0];
        else if (pend_addr_reg == OFS_SPARE2)
          spare2_reg <= pend_data_reg[7:0];
        else if (pend_addr_reg == OFS_SPAR) spar_reg <= pend_data_reg;
        else if (pend_addr_reg == OFS_CTRL) ctrl_reg <= pend_data_reg[1:0];
      end
      // alarm wake sets the power request
      // placed last so the set wins over a same-cycle control write
      if (alarm_hit && keys_ok && ctrl_reg[BIT_WAKE_EN])
        ctrl_reg[BIT_PWR_REQ] <= 1'b1;
    end
  end

  // ****************
  // alarm and outputs
  // ****************
  // mask bit 1 drops the field
  // compared one cycle after the tick so the new time is seen
  assign alarm_hit = tick_d_reg
    && (mask_reg[0] || sec_reg == asec_reg)
    && (mask_reg[1] || min_reg == amin_reg)
    && (mask_reg[2] || hou_reg == ahou_reg)
    && (mask_reg[3] || dom_reg == adom_reg)
    && (mask_reg[4] || dow_reg == adow_reg)
    && (mask_reg[5] || mth_reg == amth_reg)
    && (mask_reg[6] || yea_reg == ayea_reg);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alarm_irq    <= 1'b0;
      core_power_o <= 1'b0;
    end
    else
    begin
      alarm_irq    <= alarm_hit && keys_ok;
      // power follows request only with keys
      core_power_o <= keys_ok && ctrl_reg[BIT_PWR_REQ];
    end
  end

  // ****************
  // reset debounce
  // ****************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sysrst_deb_n <= 1'b1;
      ms_cnt_reg   <= 16'h0000;
      ms_num_reg   <= 12'h000;
    end
    else if (!deb_busy)
    begin
      ms_cnt_reg <= 16'h0000;
      ms_num_reg <= 12'h000;
    end
    else if (ms_num_reg >= deb_ms(debsp_reg[3:1]))
    begin
      sysrst_deb_n <= sysrst_in_n;
      ms_num_reg   <= 12'h000;
    end
    else if (ms_cnt_reg == 16'(MS_CYC - 1))
    begin
      ms_cnt_reg <= 16'h0000;
      ms_num_reg <= ms_num_reg + 12'h001;
    end
    else
      ms_cnt_reg <= ms_cnt_reg + 16'h0001;
  end

  // ****************
  // checks
  // ****************
  sequence s_wr_start;
    new_wr && wr_addr_reg == OFS_TSEC;
  endsequence

  a_irq_needs_keys:
    assert property (@(posedge hclk) disable iff (!hresetn)
      alarm_irq |-> $past(keys_ok))
    else $error("alarm without valid keys");

  a_power_gating:
    assert property (@(posedge hclk) disable iff (!hresetn)
      core_power_o |-> $past(keys_ok && ctrl_reg[BIT_PWR_REQ]))
    else $error("power request not gated");

  a_pend_shows:
    assert property (@(posedge hclk) disable iff (!hresetn)
      s_wr_start ##1 !new_wr |-> pend_reg [*4])
    else $error("pending flag dropped early");

  a_pend_clears:
    assert property (@(posedge hclk) disable iff (!hresetn)
      s_wr_start ##1 !new_wr [*5] |=> !pend_reg)
    else $error("pending flag stuck");

  a_all_masked:
    assert property (@(posedge hclk) disable iff (!hresetn)
      tick_d_reg && mask_reg == 7'h7F && keys_ok |=> alarm_irq)
    else $error("all-masked alarm missed");

  a_hour_mask:
    assert property (@(posedge hclk) disable iff (!hresetn)
      alarm_hit |-> mask_reg[2] || hou_reg == ahou_reg)
    else $error("hour compared wrongly");

  a_sec_wrap:
    assert property (@(posedge hclk) disable iff (!hresetn)
      tick_reg && sec_reg == SEC_MAX && !commit |=> sec_reg == 6'h00)
    else $error("seconds did not wrap");

  a_hour_range:
    assert property (@(posedge hclk) disable iff (!hresetn)
      tick_reg && hou_reg == HOU_MAX && min_reg == MIN_MAX
      && sec_reg == SEC_MAX && !commit |=> hou_reg == 5'h00)
    else $error("hours did not wrap");

  a_leap_feb:
    assert property (@(posedge hclk) disable iff (!hresetn)
      mth_reg == 4'h2 && yea_reg[1:0] == 2'h0
      |-> month_len(mth_reg, yea_reg) == 5'h1D)
    else $error("leap february wrong");

  a_deb_flag:
    assert property (@(posedge hclk) disable iff (!hresetn)
      $changed(sysrst_deb_n) |-> $past(deb_busy))
    else $error("debounce settled without busy");

endmodule // rcak_rtc
`default_nettype wire

// ### rtl/rcak_pkg.sv
// constants for the calendar, alarm and power-key block
// assumes a 50 MHz bus clock and a 32.768 kHz oscillator level input
package rcak_pkg;
  // ****************
  // register offsets
  // ****************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_TSEC   = 8'h14;
  localparam logic [7:0] OFS_TMIN   = 8'h18;
  localparam logic [7:0] OFS_THOU   = 8'h1C;
  localparam logic [7:0] OFS_TDOM   = 8'h20;
  localparam logic [7:0] OFS_TDOW   = 8'h24;
  localparam logic [7:0] OFS_TMTH   = 8'h28;
  localparam logic [7:0] OFS_TYEA   = 8'h2C;
  localparam logic [7:0] OFS_ASEC   = 8'h30;
  localparam logic [7:0] OFS_AMIN   = 8'h34;
  localparam logic [7:0] OFS_AHOU   = 8'h38;
  localparam logic [7:0] OFS_ADOM   = 8'h3C;
  localparam logic [7:0] OFS_ADOW   = 8'h40;
  localparam logic [7:0] OFS_AMTH   = 8'h44;
  localparam logic [7:0] OFS_AYEA   = 8'h48;
  localparam logic [7:0] OFS_KEYA   = 8'h50;
  localparam logic [7:0] OFS_KEYB   = 8'h54;
  localparam logic [7:0] OFS_DEBSP  = 8'h58;
  localparam logic [7:0] OFS_SPARE2 = 8'h5C;
  localparam logic [7:0] OFS_WOK    = 8'h60;
  localparam logic [7:0] OFS_SPAR   = 8'h64;
  // ***************************
  // fields, keys, reset values
  // ***************************
  localparam int          BIT_WPEND   = 15;
  localparam int          BIT_DPEND   = 14;
  localparam int          BIT_WAKE_EN = 0;
  localparam int          BIT_PWR_REQ = 1;
  localparam logic [15:0] KEY_A_OK    = 16'hA357;
  localparam logic [15:0] KEY_B_OK    = 16'h67D2;
  localparam logic [5:0]  SEC_MAX     = 6'h3B;
  localparam logic [5:0]  MIN_MAX     = 6'h3B;
  localparam logic [4:0]  HOU_MAX     = 5'h17;
  localparam logic [2:0]  DOW_MAX     = 3'h7;
  localparam logic [3:0]  MTH_MAX     = 4'hC;
  localparam logic [6:0]  YEA_MAX     = 7'h7F;
  localparam logic [4:0]  DOM_RST     = 5'h01;
  localparam logic [2:0]  DOW_RST     = 3'h1;
  localparam logic [3:0]  MTH_RST     = 4'h1;
  // ****************
  // timing
  // ****************
  localparam int          HCLK_KHZ    = 50000;
  localparam int          DEB_UNIT_MS = 1;
  localparam int          MS_CYCLES   = DEB_UNIT_MS * HCLK_KHZ;
  localparam logic [2:0]  COMMIT_CYC  = 3'h4;
  localparam logic [14:0] OSC_PER_SEC = 15'h7FFF;
endpackage

// ### verification/tb.sv
// self-checking bench for the calendar, alarm and power-key block
// assumes the block is the only AHB-Lite slave; hready is its hreadyout
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rcak_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m;} rcak_note_s;
  // ****************
  // stimulus tables
  // ****************
  localparam int MSC = 5;
  localparam int LO [7] = '{0, 0, 0, 1, 1, 1, 0};
  localparam int HI [7] = '{59, 59, 23, 28, 7, 12, 127};
  // 23:59:59 on 28 feb of leap year 4, alarm one second later
  localparam int TV [14] = '{59, 59, 23, 28, 7, 2, 4, 0, 0, 5, 29, 3, 2, 9};
  localparam int NX [7] = '{0, 0, 0, 29, 1, 2, 4};
  localparam int DEB [8] = '{2, 8, 32, 128, 256, 512, 1024, 2048};
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        osc_32k = 1'b0;
  logic        osc_run;
  logic        sysrst_in_n;
  logic        sysrst_deb_n;
  logic        alarm_irq;
  logic        core_power_o;
  logic        rd_dp = 1'b0;
  logic [15:0] v;
  logic [15:0] sv [4];
  rcak_note_s  note_q [$];
  int          n_fail;
  int          n_compared;
  int          cyc;
  int          n_irq;
  int          base;
  int          t0;

  rcak_rtc #(.MS_CYC(MSC)) dut (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hreadyout),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .osc_32k      (osc_32k),
    .sysrst_in_n  (sysrst_in_n),
    .sysrst_deb_n (sysrst_deb_n),
    .alarm_irq    (alarm_irq),
    .core_power_o (core_power_o)
  );

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // oscillator toggles every bus cycle so one second fits the run
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (osc_run)
      osc_32k <= ~osc_32k;
    if (alarm_irq === 1'b1)
      n_irq <= n_irq + 1;
  end

  // ****************
  // checking
  // ****************
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge hclk)
  begin
    rcak_note_s nt;
    if (rd_dp && hreadyout === 1'b1 && note_q.size() > 0)
    begin
      nt = note_q.pop_front();
      check(hrdata & nt.m, nt.e & nt.m);
      check({31'h0, hresp}, 32'h0);
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  function automatic logic seen_evt(input int s, input logic lv);
    case (s)
      0: return hreadyout === 1'b1;
      1: return sysrst_deb_n === lv;
      default: return n_irq != base;
    endcase
  endfunction

  // every wait is bounded; running out ends the run as a failure
  task automatic wait_evt(input int s, input logic lv, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (!seen_evt(s, lv) && n < lim);
    if (!seen_evt(s, lv))
    begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_evt(0, 1'b1, 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    if (!w)
      note_q.push_back('{d, m});
    wait_evt(0, 1'b1, 50);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, {16'h0, d}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    bus(1'b0, a, e, m);
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    osc_run = 1'b0;
    sysrst_in_n = 1'b1;
    void'($urandom(32'h0ACF));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 14; i++)
      rd(OFS_TSEC + 8'(4 * i), 32'(LO[i % 7]));
    rd(OFS_KEYA, 32'h0);
    rd(OFS_KEYB, 32'h0);
    rd(OFS_WOK, 32'h0);
    rd(OFS_DEBSP, 32'h0);
    rd(8'h4C, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 14; i++)
    begin
      v = 16'(LO[i % 7] + $urandom % (HI[i % 7] - LO[i % 7] + 1));
      wr(OFS_TSEC + 8'(4 * i), v);
      rd(OFS_TSEC + 8'(4 * i), 32'h8000, 32'h8000);
      idle(8);
      rd(OFS_TSEC + 8'(4 * i), {16'h0, v});
    end
    $display("test counter and alarm fields done");
    for (int i = 0; i < 4; i++)
      sv[i] = 16'($urandom);
    sv[0] = sv[0] & 16'h00FF;
    sv[1] = sv[1] & 16'h00FF;
    wr(OFS_DEBSP, sv[0]);
    wr(OFS_SPARE2, sv[1]);
    wr(OFS_SPAR, sv[2]);
    wr(OFS_KEYA, sv[3]);
    rd(OFS_WOK, 32'h1, 32'h1);
    wr(OFS_KEYB, ~sv[3]);
    rd(OFS_WOK, 32'h2, 32'h2);
    wr(OFS_CTRL, 16'h0);
    rd(OFS_WOK, 32'h4, 32'h4);
    wr(8'h4C, 16'hFFFF);
    idle(8);
    rd(OFS_DEBSP, {16'h0, sv[0]});
    rd(OFS_SPARE2, {16'h0, sv[1]});
    rd(OFS_SPAR, {16'h0, sv[2]});
    rd(OFS_KEYA, {16'h0, sv[3]});
    rd(OFS_KEYB, {16'h0, ~sv[3]});
    rd(OFS_WOK, 32'h0);
    rd(8'h4C, 32'h0);
    $display("test spares and keys done");
    wr(OFS_KEYA, KEY_A_OK);
    wr(OFS_KEYB, ~KEY_B_OK);
    wr(OFS_CTRL, 16'h0002);
    idle(8);
    check({31'h0, core_power_o}, 32'h0);
    wr(OFS_KEYB, KEY_B_OK);
    idle(8);
    check({31'h0, core_power_o}, 32'h1);
    wr(OFS_CTRL, 16'h0001);
    idle(8);
    check({31'h0, core_power_o}, 32'h0);
    $display("test power gating done");
    // masked fields ignored, carry into leap day
    for (int i = 0; i < 14; i++)
      wr(OFS_TSEC + 8'(4 * i), 16'(TV[i]));
    wr(OFS_MASK, 16'h0054);
    idle(8);
    base = n_irq;
    osc_run <= 1'b1;
    wait_evt(2, 1'b0, 70000);
    osc_run <= 1'b0;
    idle(20);
    check(32'(n_irq - base), 32'h1);
    check({31'h0, core_power_o}, 32'h1);
    rd(OFS_CTRL, 32'h3, 32'h3);
    for (int i = 0; i < 7; i++)
      rd(OFS_TSEC + 8'(4 * i), 32'(NX[i]));
    $display("test one second tick done");
    for (int k = 0; k < 8; k++)
    begin
      wr(OFS_DEBSP, 16'(k * 2));
      idle(8);
      sysrst_in_n <= 1'b0;
      t0 = cyc;
      idle(3);
      rd(OFS_DEBSP, 32'h4000, 32'h4000);
      wait_evt(1, 1'b0, 12000);
      t0 = cyc - t0;
      check(32'(t0 >= DEB[k] * MSC - 1 && t0 <= DEB[k] * MSC + 6), 32'h1);
      rd(OFS_DEBSP, 32'(k * 2), 32'h400E);
      wr(OFS_DEBSP, 16'h0);
      idle(8);
      sysrst_in_n <= 1'b1;
      wait_evt(1, 1'b1, 100);
    end
    $display("test debounce codes done");
    stop_test();
  end
endmodule // tb
`default_nettype wire
